/* osc_readback_regs.sv */
// main-space readback registers and oscillator indirect write path
`timescale 1ns/1ps
`default_nettype none
module osc_readback_regs (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // register port from the serial framing logic, same clock
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [osc_regs_pkg::MAIN_ADDR_W-1:0] reg_addr,
   input wire logic [osc_regs_pkg::MAIN_DATA_W-1:0] reg_wdata,
   output logic [osc_regs_pkg::MAIN_DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   // status sources from the calibration logic, same clock
   input wire logic cal_update,
   input wire logic [osc_regs_pkg::CAL_MAG_W-1:0] cal_err_magnitude_in,
   input wire logic cal_err_negative_in,
   // pin-level status, synchronised here
   input wire logic general_output_pin,
   input wire logic lock_detect_pin,
   // oscillator controls
   output logic tune_source_select,
   output logic [7:0] subband_select,
   output logic [1:0] main_out_power,
   output logic [2:0] osc_bias_level,
   output logic [1:0] divider_out_power,
   output logic divider_enable,
   output logic [2:0] divide_ratio,
   output logic osc_power_down
);
   import osc_regs_pkg::*;

   logic [MAIN_DATA_W-1:0] cal_error_reg;
   logic [1:0] status_reg;
   logic [1:0] status_meta_reg;
   logic [1:0] status_sync_reg;
   logic [SELF_TEST_W-1:0] self_test_reg;
   logic [8:0] tuning_reg;
   logic [8:0] power_reg;
   logic [8:0] divider_reg;
   logic [MAIN_DATA_W-1:0] rdata_next;

   osc_write_if osc_wr ();

   // word passes to the subsystem only for our identifier
   function automatic logic id_matches(input logic [MAIN_DATA_W-1:0] w);
      return w[IND_ID_LSB +: IND_ID_W] == OSC_ID;
   endfunction

   // decode of indirect word; registered so the subsystem sees a clean strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         osc_wr.wr <= 1'b0;
         osc_wr.addr <= 4'h0;
         osc_wr.data <= 9'h000;
      end else if (ce) begin
         osc_wr.wr <= reg_wr && (reg_addr == ADDR_INDIRECT)
            && id_matches(reg_wdata);
         osc_wr.addr <= reg_wdata[IND_ADDR_LSB +: IND_ADDR_W];
         osc_wr.data <= reg_wdata[IND_DATA_LSB +: OSC_DATA_W];
      end
   end

   osc_subsystem_regs u_osc (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .wr_in(osc_wr.dst),
      .tuning_reg(tuning_reg),
      .power_reg(power_reg),
      .divider_reg(divider_reg)
   );

   // calibration result captured when the calibration logic posts one
   always_ff @(posedge clk) begin
      if (rst) begin
         cal_error_reg <= CAL_ERROR_RESET;
      end else if (ce && cal_update) begin
         cal_error_reg <= '0;
         cal_error_reg[CAL_MAG_W-1:0] <= cal_err_magnitude_in;
         cal_error_reg[CAL_SIGN_BIT] <= cal_err_negative_in;
      end
   end

   // two-stage sync; only the second stage feeds the status word
   always_ff @(posedge clk) begin
      if (rst) begin
         status_meta_reg <= 2'h0;
         status_sync_reg <= 2'h0;
         status_reg <= LOCK_STATUS_RESET[1:0];
      end else if (ce) begin
         status_meta_reg <= {lock_detect_pin, general_output_pin};
         status_sync_reg <= status_meta_reg;
         status_reg[STAT_GPO_BIT] <= status_sync_reg[0];
         status_reg[STAT_LOCK_BIT] <= status_sync_reg[1];
      end
   end

   // self-test word has no live source here, it holds its reset value
   always_ff @(posedge clk) begin
      if (rst) begin
         self_test_reg <= SELF_TEST_RESET;
      end
   end

   // read mux; oscillator space is absent, indirect reg reads zero
   always_comb begin
      rdata_next = '0;
      if (reg_addr == ADDR_CAL_ERROR) begin
         rdata_next = cal_error_reg;
      end else if (reg_addr == ADDR_LOCK_STATUS) begin
         rdata_next[1:0] = status_reg;
      end else if (reg_addr == ADDR_SELF_TEST) begin
         rdata_next[SELF_TEST_W-1:0] = self_test_reg;
      end else begin
         rdata_next = '0;
      end
   end

   // read answer one cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= '0;
         reg_rvalid <= 1'b0;
      end else if (ce) begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rdata_next;
         end
      end
   end

   // field outputs registered; reserved bits are dropped, host keeps them zero
   always_ff @(posedge clk) begin
      if (rst) begin
         tune_source_select <= 1'b0;
         subband_select <= OSC_TUNING_RESET[SUBBAND_LSB +: 8];
         main_out_power <= 2'h0;
         osc_bias_level <= 3'h0;
         divider_out_power <= 2'h0;
         divider_enable <= 1'b0;
         divide_ratio <= RATIO_BYPASS;
         osc_power_down <= 1'b0;
      end else if (ce) begin
         tune_source_select <= tuning_reg[TUNE_SRC_BIT];
         subband_select <= tuning_reg[SUBBAND_LSB +: 8];
         main_out_power <= power_reg[MAIN_PWR_LSB +: 2];
         osc_bias_level <= power_reg[BIAS_LSB +: 3];
         divider_out_power <= power_reg[DIV_PWR_LSB +: 2];
         divider_enable <= power_reg[DIV_EN_BIT];
         // ratio only meaningful with divider on; otherwise report bypass
         if (power_reg[DIV_EN_BIT]) begin
            divide_ratio <= divider_reg[RATIO_LSB +: 3];
         end else begin
            divide_ratio <= RATIO_BYPASS;
         end
         osc_power_down <= divider_reg[OSC_PD_BIT];
      end
   end
endmodule
`default_nettype wire

/* osc_regs_pkg.sv */
// constants for the synthesizer readback and oscillator indirect register block
package osc_regs_pkg;
   // main register space
   localparam int MAIN_ADDR_W = 6;
   localparam int MAIN_DATA_W = 24;
   localparam logic [5:0] ADDR_INDIRECT = 6'h05;
   localparam logic [5:0] ADDR_CAL_ERROR = 6'h11;
   localparam logic [5:0] ADDR_LOCK_STATUS = 6'h12;
   localparam logic [5:0] ADDR_SELF_TEST = 6'h13;
   // readback reset values
   localparam logic [23:0] CAL_ERROR_RESET = 24'h07FFFF;
   localparam logic [23:0] LOCK_STATUS_RESET = 24'h000000;
   localparam logic [16:0] SELF_TEST_RESET = 17'h01259;
   // readback field positions
   localparam int CAL_MAG_W = 19;
   localparam int CAL_SIGN_BIT = 19;
   localparam int STAT_GPO_BIT = 0;
   localparam int STAT_LOCK_BIT = 1;
   localparam int SELF_TEST_W = 17;
   // indirect word layout
   localparam int IND_ID_LSB = 0;
   localparam int IND_ID_W = 3;
   localparam int IND_ADDR_LSB = 3;
   localparam int IND_ADDR_W = 4;
   localparam int IND_DATA_LSB = 7;
   localparam int OSC_DATA_W = 9;
   localparam logic [2:0] OSC_ID = 3'h0;
   // oscillator register addresses
   localparam logic [3:0] OSC_TUNING = 4'h0;
   localparam logic [3:0] OSC_POWER = 4'h1;
   localparam logic [3:0] OSC_DIVIDER = 4'h2;
   // oscillator register reset values (subband 16 in bits 8:1)
   localparam logic [8:0] OSC_TUNING_RESET = 9'h020;
   localparam logic [8:0] OSC_POWER_RESET = 9'h000;
   localparam logic [8:0] OSC_DIVIDER_RESET = 9'h000;
   // oscillator field positions
   localparam int TUNE_SRC_BIT = 0;
   localparam int SUBBAND_LSB = 1;
   localparam int MAIN_PWR_LSB = 0;
   localparam int BIAS_LSB = 2;
   localparam int DIV_PWR_LSB = 5;
   localparam int DIV_EN_BIT = 8;
   localparam int RATIO_LSB = 0;
   localparam int OSC_PD_BIT = 3;
   localparam logic [2:0] RATIO_BYPASS = 3'h7;
endpackage

/* osc_write_if.sv */
// carrier for decoded oscillator writes from the main space
`timescale 1ns/1ps
`default_nettype none
interface osc_write_if;
   logic wr;
   logic [3:0] addr;
   logic [8:0] data;
   modport src (output wr, output addr, output data);
   modport dst (input wr, input addr, input data);
endinterface
`default_nettype wire

/* osc_subsystem_regs.sv */
// write-only oscillator subsystem register set
`timescale 1ns/1ps
`default_nettype none
module osc_subsystem_regs (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   osc_write_if.dst wr_in,
   output logic [8:0] tuning_reg,
   output logic [8:0] power_reg,
   output logic [8:0] divider_reg
);
   import osc_regs_pkg::*;

   // held only here; no path back to the read mux
   always_ff @(posedge clk) begin
      if (rst) begin
         tuning_reg <= OSC_TUNING_RESET;
         power_reg <= OSC_POWER_RESET;
         divider_reg <= OSC_DIVIDER_RESET;
      end else if (ce && wr_in.wr) begin
         if (wr_in.addr == OSC_TUNING) begin
            tuning_reg <= wr_in.data;
         end else if (wr_in.addr == OSC_POWER) begin
            power_reg <= wr_in.data;
         end else if (wr_in.addr == OSC_DIVIDER) begin
            divider_reg <= wr_in.data;
         end
      end
   end
endmodule
`default_nettype wire

/* osc_readback_regs_assertions.sv */
// assertion checker for the readback and indirect register block
`timescale 1ns/1ps
`default_nettype none
module osc_readback_regs_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [5:0] reg_addr,
   input wire logic [23:0] reg_wdata,
   input wire logic [23:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic tune_source_select,
   input wire logic [7:0] subband_select,
   input wire logic [1:0] main_out_power,
   input wire logic [2:0] osc_bias_level,
   input wire logic [1:0] divider_out_power,
   input wire logic divider_enable,
   input wire logic [2:0] divide_ratio,
   input wire logic osc_power_down
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [95:0] wd_hist_reg;
   // write data history, oldest word on top
   always_ff @(posedge clk) begin
      wd_hist_reg <= {wd_hist_reg[71:0], reg_wdata};
   end
   // valid indirect write aimed at the oscillator
   wire iw = ce && reg_wr && reg_addr == 6'h05 && reg_wdata[2:0] == 3'h0;
   a_rvalid_after_read: assert property (ce && reg_rd |=> reg_rvalid)
      else $error("read gave no valid");
   a_no_stray_valid: assert property (!(ce && reg_rd) |=> !reg_rvalid)
      else $error("valid without read");
   a_self_test_read: assert property (ce && reg_rd && reg_addr == 6'h13 |=>
      reg_rdata == 24'h001259) else $error("self-test value wrong");
   a_osc_unreadable: assert property (ce && reg_rd && reg_addr == 6'h05 |=>
      reg_rdata == 24'h000000) else $error("indirect port read back data");
   a_bad_id_ignored: assert property (ce && reg_wr && reg_addr == 6'h05 &&
      reg_wdata[2:0] != 3'h0 |=> ($stable(subband_select) && $stable(osc_power_down)) [*3])
      else $error("foreign identifier changed oscillator");
   a_tuning_write: assert property (iw && reg_wdata[6:3] == 4'h0 |-> ##4
      {subband_select, tune_source_select} == wd_hist_reg[87:79]) else $error("tuning wrong");
   a_power_write: assert property (iw && reg_wdata[6:3] == 4'h1 |-> ##4
      {divider_enable, divider_out_power, osc_bias_level, main_out_power} ==
      {wd_hist_reg[87], wd_hist_reg[85:79]}) else $error("power control wrong");
   a_divider_write: assert property (iw && reg_wdata[6:3] == 4'h2 |-> ##4
      osc_power_down == wd_hist_reg[82]) else $error("power down wrong");
   a_ratio_gated: assert property (!divider_enable |-> divide_ratio == 3'h7)
      else $error("ratio shown while divider off");
endmodule
`default_nettype wire

/* host_model.sv */
// host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clk,
   input wire logic [23:0] reg_rdata,
   input wire logic reg_rvalid,
   output logic reg_wr,
   output logic reg_rd,
   output logic [5:0] reg_addr,
   output logic [23:0] reg_wdata
);
   // idle port at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 24'h000000;
   end
   // one-cycle strobe; data inverted after so stale words never look valid
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   // read strobe, then a bounded wait; data taken at the edge that samples valid high
   task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic ok);
      int n;
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      ok = 1'b0;
      d = '0;
      for (n = 0; n < 4; n++) begin
         @(posedge clk);
         if (!ok && reg_rvalid === 1'b1) begin
            ok = 1'b1;
            d = reg_rdata;
         end
      end
   endtask
endmodule
`default_nettype wire

/* test_osc_readback_regs.sv */
// self-checking bench for the readback and indirect register block
`timescale 1ns/1ps
`default_nettype none
module test_osc_readback_regs;
   import osc_regs_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic cal_update = 1'b0;
   logic [18:0] cal_err_magnitude_in = '0;
   logic cal_err_negative_in = 1'b0;
   logic general_output_pin = 1'b0;
   logic lock_detect_pin = 1'b0;
   logic reg_wr, reg_rd, reg_rvalid, ok;
   logic [5:0] reg_addr;
   logic [23:0] reg_wdata, reg_rdata, got;
   logic tune_source_select, divider_enable, osc_power_down;
   logic [7:0] subband_select;
   logic [1:0] main_out_power, divider_out_power;
   logic [2:0] osc_bias_level, divide_ratio;
   logic [8:0] shadow [3];
   logic [8:0] msk [3] = '{9'h1FF, 9'h17F, 9'h00F};
   logic [8:0] corner [3] = '{9'h001, 9'h17F, 9'h19A};
   int n_mismatch = 0;
   int samples_checked = 0;
   wire [23:0] ctl = {3'h0, tune_source_select, subband_select, main_out_power,
      osc_bias_level, divider_out_power, divider_enable, divide_ratio, osc_power_down};
   osc_readback_regs osc_readback_regs_inst (.*);
   host_model host_model_inst (.*);
   always #20 clk = ~clk;
   // control outputs expected from the three oscillator words
   function automatic logic [23:0] exp_ctl(input logic [8:0] t, p, v);
      return {3'h0, t[0], t[8:1], p[1:0], p[4:2], p[6:5], p[8], p[8] ? v[2:0] : 3'h7, v[3]};
   endfunction
   task automatic chk(input logic [23:0] g, e);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // read and compare; a lost valid pulse ends the run
   task automatic rchk(input logic [5:0] a, input logic [23:0] e);
      host_model_inst.rd(a, got, ok);
      if (!ok) begin
         n_mismatch++;
         $display("mismatch at %0t: no read valid for address %h", $time, a);
         stop_test();
      end else begin
         chk(got, e);
      end
   endtask
   task automatic stop_test;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // main sequence: reset values, indirect writes, status readback
   initial begin
      logic [3:0] a;
      logic [8:0] d;
      logic [2:0] id;
      void'($urandom(32'h0411));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rchk(6'h11, 24'h07FFFF);
      rchk(6'h12, 24'h000000);
      rchk(6'h13, 24'h001259);
      chk(ctl, exp_ctl(9'h020, 9'h000, 9'h000));
      $display("reset values done");
      shadow = '{9'h020, 9'h000, 9'h000};
      for (int i = 0; i < 24; i++) begin
         a = (i < 3) ? 4'(2 - i) : 4'($urandom_range(2));
         d = (i < 3) ? corner[i] : 9'($urandom) & msk[a];
         id = (i % 4 == 3) ? 3'($urandom_range(7, 1)) : 3'h0;
         host_model_inst.wr(i % 5 == 4 ? 6'h06 : 6'h05, {8'h00, d, a, id});
         if (id == 3'h0 && i % 5 != 4) shadow[a] = d;
         repeat (6) @(posedge clk);
         chk(ctl, exp_ctl(shadow[0], shadow[1], shadow[2]));
      end
      rchk(6'h05, 24'h000000);
      $display("indirect writes done");
      // a write strobe seen while the clock enable is low must be lost
      ce <= 1'b0;
      host_model_inst.wr(6'h05, {8'h00, ~shadow[0], 4'h0, 3'h0});
      repeat (4) @(posedge clk);
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      chk(ctl, exp_ctl(shadow[0], shadow[1], shadow[2]));
      $display("clock enable hold done");
      for (int i = 0; i < 4; i++) begin
         cal_err_magnitude_in <= 19'($urandom);
         cal_err_negative_in <= 1'($urandom);
         general_output_pin <= 1'($urandom);
         lock_detect_pin <= 1'($urandom);
         cal_update <= 1'b1;
         @(posedge clk);
         cal_update <= 1'b0;
         repeat (4) @(posedge clk);
         rchk(6'h11, {4'h0, cal_err_negative_in, cal_err_magnitude_in});
         rchk(6'h12, {22'h0, lock_detect_pin, general_output_pin});
      end
      $display("status readback done");
      stop_test();
   end
endmodule
bind osc_readback_regs osc_readback_regs_assertions osc_readback_regs_assertions_inst (.*);
`default_nettype wire
